// >>> ahrp_burst_timer.sv
// Burst tone and pause sequencer
`timescale 1ns/1ps
module ahrp_burst_timer
	import ahrp_pkg::*;
#(
	parameter int BURST_LEN = BURST_CYCLES,
	parameter int BURST_CP_LEN = BURST_CP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic start,
	input wire logic enable,
	input wire logic long_mode,
	// Results
	output logic tone_on,
	output logic done
);
	ahrp_burst_t state_q;
	logic [25:0] cnt_q;
	logic [25:0] len;

	assign len = long_mode ? 26'(BURST_CP_LEN - 1) : 26'(BURST_LEN - 1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= AHRP_B_IDLE;
			cnt_q <= 26'h000_0000;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state_q)
			AHRP_B_IDLE: begin
				cnt_q <= 26'h000_0000;
				if (start && enable) begin
					state_q <= AHRP_B_TONE;
				end
			end
			AHRP_B_TONE: begin
				if (!enable) begin
					state_q <= AHRP_B_IDLE;
				end else if (cnt_q == len) begin
					cnt_q <= 26'h000_0000;
					state_q <= AHRP_B_PAUSE;
				end else begin
					cnt_q <= cnt_q + 26'h000_0001;
				end
			end
			AHRP_B_PAUSE: begin
				if (!enable) begin
					state_q <= AHRP_B_IDLE;
				end else if (cnt_q == len) begin
					state_q <= AHRP_B_IDLE;
					done <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 26'h000_0001;
				end
			end
			default: begin
				state_q <= AHRP_B_IDLE;
			end
			endcase
		end
	end

	assign tone_on = (state_q == AHRP_B_TONE);
endmodule : ahrp_burst_timer

// >>> ahrp_host.sv
// Host bus master model driving the register port pins
`timescale 1ns/1ps
module ahrp_host (
	// Clock
	input wire logic clk,
	// Bus pins
	output logic chip_select_n,
	output logic data_strobe_in,
	output logic rw_or_write_n,
	output logic addr_strobe,
	output logic register_select,
	output logic [3:0] data_in,
	input wire logic [3:0] data_out
);
	initial begin
		chip_select_n = 1'b1;
		data_strobe_in = 1'b0;
		rw_or_write_n = 1'b1;
		addr_strobe = 1'b0;
		register_select = 1'b0;
		data_in = 4'h0;
	end
	// One access, each with its own chip select fall
	task automatic acc(input logic sp, mx, rs, w, input logic [3:0] d,
		output logic [3:0] q);
		@(posedge clk);
		chip_select_n <= 1'b0;
		data_strobe_in <= sp;
		rw_or_write_n <= 1'b1;
		addr_strobe <= mx;
		register_select <= rs;
		@(posedge clk);
		addr_strobe <= 1'b0;
		// A muxed bus moves the shared lines once the address is latched
		if (mx)
			register_select <= ~rs;
		data_strobe_in <= sp ? w : 1'b1;
		rw_or_write_n <= !w;
		data_in <= d;
		repeat (3) @(posedge clk);
		q = data_out;
		data_strobe_in <= sp;
		rw_or_write_n <= 1'b1;
		repeat (2) @(posedge clk);
		chip_select_n <= 1'b1;
		data_in <= ~d;
		@(posedge clk);
	endtask : acc
endmodule : ahrp_host

// >>> ahrp_pkg.sv
// Constants, register map and field positions for the adaptive host register port
package ahrp_pkg;
	// Register select decode
	localparam logic REG_DATA = 1'b0;
	localparam logic REG_CTRL = 1'b1;
	// Control primary fields
	localparam int CP_TONE_EN = 0;
	localparam int CP_MODE = 1;
	localparam int CP_IRQ_EN = 2;
	localparam int CP_REDIRECT = 3;
	// Control secondary fields
	localparam int CS_BURST_N = 0;
	localparam int CS_TEST = 1;
	localparam int CS_SINGLE = 2;
	localparam int CS_COLUMN = 3;
	// Status fields
	localparam int ST_IRQ = 0;
	localparam int ST_TX_EMPTY = 1;
	localparam int ST_RX_FULL = 2;
	localparam int ST_DSTEER = 3;
	// Reset values
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [3:0] DIGIT_RESET = 4'h0;
	// Burst timing
	localparam int CLK_HZ = 200_000_000;
	localparam int BURST_MS = 51;
	localparam int BURST_CP_MS = 102;
	localparam int BURST_CYCLES = CLK_HZ / 1000 * BURST_MS;
	localparam int BURST_CP_CYCLES = CLK_HZ / 1000 * BURST_CP_MS;
	// Bus styles
	typedef enum logic [1:0] {
		AHRP_STYLE_STROBE = 2'b00,
		AHRP_STYLE_SPLIT = 2'b01
	} ahrp_style_t;
	// Burst sequencer states, Gray along idle-tone-pause
	typedef enum logic [1:0] {
		AHRP_B_IDLE = 2'b00,
		AHRP_B_TONE = 2'b01,
		AHRP_B_PAUSE = 2'b11
	} ahrp_burst_t;
endpackage : ahrp_pkg

// >>> ahrp_port.sv
// Adaptive host register port of the tone transceiver
`timescale 1ns/1ps

// How it works
// - Data strobe low at chip select fall selects strobe plus read/write style.
// - Read strobe high at chip select fall selects split read/write strobes.
// - One internal qualifier gates every register access in both styles.
// - Multiplexed buses latch select at address strobe, else at access.
// - Status flags update from events without host strobe activity.
// - Select 0 writes transmit, reads receive; 1 writes control, reads status.
// - Receive register is read-only, holds latest valid digit code.
// - Transmit register is write-only, its code selects the tone pair.
// - Primary bit 3 sends only the next control write to secondary.
// - Status register is read-only and shows present transceiver state.
// - Primary bit 0 enables tone output, gating all transmit tones.
// - Primary bit 1 high selects call progress, low dual-tone mode.
// - Call progress with interrupts enabled puts tone square wave on pin.
// - Call progress mode detects and reports no digits.
// - Interrupt enable pulls pin low on valid digit or burst ready.
// - Interrupt pin is open drain: pulls low or releases.
// - Primary bits: redirect, interrupt enable, mode select, tone enable.
// - Secondary bits: column/row, single/dual, test, burst enable low.
// - Status read clears irq, empty, full; steering follows tone presence.
// - Burst mode gives equal 51 ms burst and pause, 102 ms in progress mode.
// - Single tone selected by bit 2, bit 3 picks column or row.
// - Test bit in dual-tone mode mirrors delayed steering on the pin.
module ahrp_port
	import ahrp_pkg::*;
#(
	parameter int BURST_LEN = BURST_CYCLES,
	parameter int BURST_CP_LEN = BURST_CP_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host bus pins
	input wire logic chip_select_n,
	input wire logic data_strobe_in,
	input wire logic rw_or_write_n,
	input wire logic addr_strobe,
	input wire logic register_select,
	input wire logic [3:0] data_in,
	output logic [3:0] data_out,
	output logic data_oe,
	// Interrupt or call progress pin
	input wire logic irq_or_progress_in,
	output logic irq_or_progress_out,
	output logic irq_or_progress_oe,
	// Receiver side events
	input wire logic rx_digit_valid,
	input wire logic [3:0] rx_digit_code,
	input wire logic rx_tone_present,
	input wire logic cp_tone_level,
	// Transmitter controls
	output logic [3:0] tx_code,
	output logic tx_tone_on,
	output logic tx_single_tone,
	output logic tx_column_tone,
	output logic call_progress_mode
);
	logic split_style;
	logic muxed_bus;
	logic rd_pulse;
	logic wr_pulse;
	logic rs_latched_q;
	logic rs_eff;
	logic redirect_q;
	logic [3:0] control_primary_q;
	logic [3:0] control_secondary_q;
	logic [3:0] receive_digit_q;
	logic [3:0] transmit_digit_q;
	logic irq_q;
	logic tx_empty_q;
	logic rx_full_q;
	logic dsteer_q;
	logic status_read;
	logic burst_mode;
	logic burst_start;
	logic burst_tone;
	logic burst_done;
	logic tone_en;
	logic digit_evt;
	logic pin_low;
	logic ctrl_wr;

	ahrp_style_detect u_detect (
		.clk(clk),
		.rst(rst),
		.chip_select_n(chip_select_n),
		.data_strobe_in(data_strobe_in),
		.rw_or_write_n(rw_or_write_n),
		.addr_strobe(addr_strobe),
		.split_style(split_style),
		.muxed_bus(muxed_bus),
		.rd_pulse(rd_pulse),
		.wr_pulse(wr_pulse)
	);

	// Register select held from address strobe on multiplexed buses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rs_latched_q <= 1'b0;
		end else if (addr_strobe) begin
			rs_latched_q <= register_select;
		end
	end
	assign rs_eff = muxed_bus ? rs_latched_q : register_select;

	assign status_read = rd_pulse && rs_eff == REG_CTRL;
	assign tone_en = control_primary_q[CP_TONE_EN];
	assign call_progress_mode = control_primary_q[CP_MODE];
	assign burst_mode = ~control_secondary_q[CS_BURST_N];
	assign digit_evt = rx_digit_valid & ~call_progress_mode;
	assign burst_start = wr_pulse && rs_eff == REG_DATA && burst_mode;

	// Control writes and redirect pointer
	assign ctrl_wr = wr_pulse && rs_eff == REG_CTRL;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			control_primary_q <= CTRL_RESET;
		end else if (ctrl_wr && !redirect_q) begin
			control_primary_q <= data_in;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			control_secondary_q <= CTRL_RESET;
		end else if (ctrl_wr && redirect_q) begin
			control_secondary_q <= data_in;
		end
	end

	// Pointer sends exactly one control write to the secondary register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			redirect_q <= 1'b0;
		end else if (ctrl_wr) begin
			if (redirect_q) begin
				redirect_q <= 1'b0;
			end else begin
				redirect_q <= data_in[CP_REDIRECT];
			end
		end
	end

	// Transmit digit, write only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			transmit_digit_q <= DIGIT_RESET;
		end else if (wr_pulse && rs_eff == REG_DATA) begin
			transmit_digit_q <= data_in;
		end
	end

	// Receive digit, read only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			receive_digit_q <= DIGIT_RESET;
		end else if (digit_evt) begin
			receive_digit_q <= rx_digit_code;
		end
	end

	ahrp_burst_timer #(
		.BURST_LEN(BURST_LEN),
		.BURST_CP_LEN(BURST_CP_LEN)
	) u_burst (
		.clk(clk),
		.rst(rst),
		.start(burst_start),
		.enable(burst_mode & tone_en),
		.long_mode(call_progress_mode),
		.tone_on(burst_tone),
		.done(burst_done)
	);

	// Delayed steering is low while a valid tone stands
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dsteer_q <= 1'b1;
		end else begin
			dsteer_q <= ~(rx_tone_present & ~call_progress_mode);
		end
	end

	// Receive full: a new digit wins over a status read in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_full_q <= 1'b0;
		end else if (digit_evt) begin
			rx_full_q <= 1'b1;
		end else if (status_read) begin
			rx_full_q <= 1'b0;
		end
	end

	// Transmit empty only has meaning in burst mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_empty_q <= 1'b0;
		end else if (burst_done) begin
			tx_empty_q <= 1'b1;
		end else if (status_read || !burst_mode) begin
			tx_empty_q <= 1'b0;
		end
	end

	// Interrupt flag collects both events, so no event is lost to a read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else if (digit_evt || burst_done) begin
			irq_q <= 1'b1;
		end else if (status_read) begin
			irq_q <= 1'b0;
		end
	end

	// Bus drive holds from the read start until chip select rises
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_oe <= 1'b0;
		end else begin
			data_oe <= rd_pulse | (data_oe & ~chip_select_n);
		end
	end

	// Read data is captured once per read and then held
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_out <= 4'h0;
		end else if (rd_pulse) begin
			if (rs_eff == REG_DATA) begin
				data_out <= receive_digit_q;
			end else begin
				data_out <= {dsteer_q, rx_full_q, tx_empty_q, irq_q};
			end
		end
	end

	// Interrupt or call progress pin drive
	always_comb begin
		pin_low = 1'b0;
		if (call_progress_mode) begin
			pin_low = control_primary_q[CP_IRQ_EN] & ~cp_tone_level;
		end else if (control_secondary_q[CS_TEST]) begin
			pin_low = ~dsteer_q;
		end else if (control_primary_q[CP_IRQ_EN]) begin
			pin_low = irq_q;
		end
	end

	// The pin is only ever pulled low; the pull-up gives the high level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_or_progress_out <= 1'b0;
		end else begin
			irq_or_progress_out <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_or_progress_oe <= 1'b0;
		end else begin
			irq_or_progress_oe <= pin_low;
		end
	end

	// Transmit code follows the written digit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_code <= DIGIT_RESET;
		end else begin
			tx_code <= transmit_digit_q;
		end
	end

	// Tone gate: enable bit always, burst timer only in burst mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_tone_on <= 1'b0;
		end else begin
			tx_tone_on <= tone_en & (burst_mode ? burst_tone : 1'b1);
		end
	end

	// Single tone and its group come straight from the secondary register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_single_tone <= 1'b0;
		end else begin
			tx_single_tone <= control_secondary_q[CS_SINGLE];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_column_tone <= 1'b0;
		end else begin
			tx_column_tone <= control_secondary_q[CS_COLUMN];
		end
	end
endmodule : ahrp_port

// >>> ahrp_port_props.sv
// Assertion checker for the adaptive host register port
`timescale 1ns/1ps
module ahrp_port_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host pins
	input wire logic chip_select_n,
	input wire logic data_strobe_in,
	input wire logic rw_or_write_n,
	// Outputs
	input wire logic [3:0] data_out,
	input wire logic data_oe,
	input wire logic irq_or_progress_out,
	input wire logic irq_or_progress_oe,
	input wire logic [3:0] tx_code,
	input wire logic tx_tone_on,
	input wire logic call_progress_mode
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic cs_q;
	logic split_q;
	logic rd_q;
	logic rd;
	logic wr;
	logic [3:0] wr_h;
	// Strobes only count after the chip select fall has fixed the style
	assign rd = !chip_select_n && !cs_q
		&& (split_q ? !data_strobe_in : data_strobe_in && rw_or_write_n);
	assign wr = !chip_select_n && !cs_q
		&& (split_q ? !rw_or_write_n : data_strobe_in && !rw_or_write_n);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_q <= 1'b1;
			split_q <= 1'b0;
			rd_q <= 1'b0;
			wr_h <= 4'h0;
		end else begin
			cs_q <= chip_select_n;
			if (cs_q && !chip_select_n)
				split_q <= data_strobe_in;
			rd_q <= rd;
			wr_h <= {wr_h[2:0], wr};
		end
	end
	a_od_low_only: assert property (irq_or_progress_out == 1'b0)
		else $error("open drain pin driven high");
	a_read_answer: assert property (rd && !rd_q |=> data_oe)
		else $error("read not answered");
	a_write_quiet: assert property (wr |-> !data_oe)
		else $error("bus driven in write");
	a_oe_stands: assert property (data_oe && !chip_select_n |=> data_oe)
		else $error("read data dropped early");
	a_oe_drop: assert property (chip_select_n |=> !data_oe)
		else $error("bus driven without select");
	a_out_holds: assert property (!(rd && !rd_q) |=> $stable(data_out))
		else $error("read data moved without read");
	a_reset_quiet: assert property ($fell(rst) |-> !data_oe && !tx_tone_on
		&& !irq_or_progress_oe)
		else $error("outputs active after reset");
	a_code_cause: assert property ($changed(tx_code) |-> |wr_h)
		else $error("transmit code moved without write");
	a_mode_cause: assert property ($changed(call_progress_mode) |-> |wr_h)
		else $error("mode moved without write");
	c_read: cover property (rd && !rd_q);
	c_write: cover property (wr);
	c_cp_pin: cover property (call_progress_mode && irq_or_progress_oe);
endmodule : ahrp_port_props

bind ahrp_port ahrp_port_props ahrp_port_props_i (.clk, .rst, .chip_select_n,
	.data_strobe_in, .rw_or_write_n, .data_out, .data_oe, .irq_or_progress_out,
	.irq_or_progress_oe, .tx_code, .tx_tone_on, .call_progress_mode);

// >>> ahrp_style_detect.sv
// Bus style detection and internal access qualifier
`timescale 1ns/1ps
module ahrp_style_detect
	import ahrp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host pins
	input wire logic chip_select_n,
	input wire logic data_strobe_in,
	input wire logic rw_or_write_n,
	input wire logic addr_strobe,
	// Decoded access
	output logic split_style,
	output logic muxed_bus,
	output logic rd_pulse,
	output logic wr_pulse
);
	logic cs_prev_q;
	logic ds_prev_q;
	logic wr_prev_q;
	logic cs_fall;
	ahrp_style_t style_q;
	logic muxed_q;
	logic rd_act;
	logic wr_act;

	assign cs_fall = cs_prev_q & ~chip_select_n;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_prev_q <= 1'b1;
			ds_prev_q <= 1'b0;
			wr_prev_q <= 1'b0;
		end else begin
			cs_prev_q <= chip_select_n;
			ds_prev_q <= rd_act;
			wr_prev_q <= wr_act;
		end
	end

	// Style captured at every chip select fall
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			style_q <= AHRP_STYLE_STROBE;
			muxed_q <= 1'b0;
		end else if (cs_fall) begin
			if (!data_strobe_in) begin
				style_q <= AHRP_STYLE_STROBE;
			end else begin
				style_q <= AHRP_STYLE_SPLIT;
			end
			muxed_q <= addr_strobe;
		end
	end

	// Equivalent internal qualifier for either style
	always_comb begin
		rd_act = 1'b0;
		wr_act = 1'b0;
		// Nothing counts in the fall cycle, before the style is known
		if (!chip_select_n && !cs_prev_q) begin
			if (style_q == AHRP_STYLE_SPLIT) begin
				rd_act = ~data_strobe_in;
				wr_act = ~rw_or_write_n;
			end else begin
				rd_act = data_strobe_in & rw_or_write_n;
				wr_act = data_strobe_in & ~rw_or_write_n;
			end
		end
	end

	assign split_style = (style_q == AHRP_STYLE_SPLIT);
	assign muxed_bus = muxed_q;
	assign rd_pulse = rd_act & ~ds_prev_q;
	// Write commits at strobe end, when data is stable
	assign wr_pulse = wr_prev_q & ~wr_act;
endmodule : ahrp_style_detect

// >>> test_adaptive_host_register_port.sv
// Self-checking bench for the adaptive host register port
`timescale 1ns/1ps
module test_adaptive_host_register_port;
	localparam int BL = 20;
	logic clk, rst, chip_select_n, data_strobe_in, rw_or_write_n;
	logic addr_strobe, register_select, irq_or_progress_in;
	logic irq_or_progress_out, irq_or_progress_oe, rx_digit_valid;
	logic rx_tone_present, cp_tone_level, tx_tone_on, tx_single_tone;
	logic tx_column_tone, call_progress_mode;
	logic [3:0] data_in, data_out, rx_digit_code, tx_code, q, c;
	logic [3:0] digs[$];
	int err_total, n_checks, tone_n;
	// Pull-up on the open drain pin
	assign irq_or_progress_in = irq_or_progress_oe ? irq_or_progress_out : 1'b1;
	ahrp_port #(.BURST_LEN(BL), .BURST_CP_LEN(2 * BL)) ahrp_port_i (.clk, .rst,
		.chip_select_n, .data_strobe_in, .rw_or_write_n, .addr_strobe,
		.register_select, .data_in, .data_out, .data_oe(),
		.irq_or_progress_in, .irq_or_progress_out, .irq_or_progress_oe,
		.rx_digit_valid, .rx_digit_code, .rx_tone_present, .cp_tone_level,
		.tx_code, .tx_tone_on, .tx_single_tone, .tx_column_tone,
		.call_progress_mode);
	ahrp_host ahrp_host_i (.clk, .chip_select_n, .data_strobe_in,
		.rw_or_write_n, .addr_strobe, .register_select, .data_in, .data_out);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) if (tx_tone_on) tone_n++;
	task automatic chk(input logic [3:0] g, e, input string m);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic sp, r, input logic [3:0] d);
		ahrp_host_i.acc(sp, 1'b0, r, 1'b1, d, q);
	endtask : wr
	task automatic rd(input logic sp, mx, r, input logic [3:0] e, string m);
		ahrp_host_i.acc(sp, mx, r, 1'b0, 4'h0, q);
		chk(q, e, m);
	endtask : rd
	task automatic dig(input logic [3:0] d);
		@(posedge clk);
		rx_digit_valid <= 1'b1;
		rx_digit_code <= d;
		@(posedge clk);
		rx_digit_valid <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : dig
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results
	initial begin
		#50000;
		err_total++;
		results();
	end
	initial begin
		rst = 1'b1;
		rx_digit_valid = 1'b0;
		rx_digit_code = 4'h0;
		rx_tone_present = 1'b0;
		cp_tone_level = 1'b0;
		err_total = 0;
		n_checks = 0;
		tone_n = 0;
		void'($urandom(18723));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rd(1, 0, 1, 4'h8, "st0");
		wr(1, 1, 4'h2);
		chk(4'(call_progress_mode), 4'h1, "ptr");
		wr(1, 1, 4'h0);
		wr(1, 1, 4'h0);
		wr(1, 1, 4'h8);
		wr(1, 1, 4'h0);
		wr(1, 1, 4'hA);
		wr(1, 1, 4'hC);
		chk({tx_column_tone, tx_single_tone, 1'b0, call_progress_mode}, 4'hD,
			"crb");
		wr(1, 1, 4'h0);
		chk(4'({tx_single_tone, call_progress_mode}), 4'h2, "cra");
		$display("test ctrl done");
		wr(0, 1, 4'h4);
		for (int i = 0; i < 3; i++) begin
			c = 4'($urandom);
			rx_tone_present <= 1'b1;
			dig(c);
			digs.push_back(c);
			chk(4'(irq_or_progress_in), 4'h0, "irq");
			rd(0, 1, 0, digs.pop_front(), "rx");
			rd(0, 1, 1, 4'h5, "st1");
			chk(4'(irq_or_progress_in), 4'h1, "clr");
			rx_tone_present <= 1'b0;
			repeat (3) @(posedge clk);
			rd(1, 0, 1, 4'h8, "st2");
		end
		$display("test rx done");
		wr(1, 1, 4'hD);
		wr(1, 1, 4'h0);
		c = 4'($urandom);
		tone_n = 0;
		wr(0, 0, c);
		chk(tx_code, c, "txc");
		for (int i = 0; i < 200 && irq_or_progress_in; i++)
			@(posedge clk);
		chk(4'(tone_n == BL), 4'h1, "len");
		rd(1, 0, 1, 4'hB, "st3");
		wr(1, 1, 4'h4);
		tone_n = 0;
		wr(0, 0, c);
		repeat (30) @(posedge clk);
		chk(4'(tone_n == 0), 4'h1, "off");
		$display("test burst done");
		wr(1, 1, 4'h6);
		for (int i = 0; i < 8; i++) begin
			cp_tone_level <= 1'($urandom);
			repeat (3) @(posedge clk);
			chk(4'(irq_or_progress_in), 4'(cp_tone_level), "cp");
		end
		dig(4'h5);
		rd(1, 0, 1, 4'h8, "st4");
		wr(1, 1, 4'h7);
		tone_n = 0;
		wr(0, 0, c);
		repeat (90) @(posedge clk);
		chk(4'(tone_n == 2 * BL), 4'h1, "cpl");
		rd(1, 0, 1, 4'hB, "st5");
		$display("test cp done");
		wr(1, 1, 4'h8);
		wr(1, 1, 4'h3);
		rx_tone_present <= 1'b1;
		repeat (3) @(posedge clk);
		chk(4'(irq_or_progress_in), 4'h0, "tst");
		rx_tone_present <= 1'b0;
		repeat (3) @(posedge clk);
		chk(4'(irq_or_progress_in), 4'h1, "tst");
		$display("test mode done");
		results();
	end
endmodule : test_adaptive_host_register_port
